// File: pmu_top.sv
// Purpose: fast and slow modulators with closed and open loop margining
// Assumes: clk_i is the fast source clock; pins synchronous to clk_i
// Notes:   duty fraction of 1/16 cycle is realised by period-to-period dither
//
// Contract
// - fast output period is the clock divided by one integer, 2 to 16383.
// - each pair of fast channels shares one divisor register.
// - fast duty has sixteen sub-steps per source clock period.
// - general-output fast pins act independent of the partner's mode.
// - general-output fast pins are driven low from reset onward.
// - enabling one fast channel also modulates an unassigned partner.
// - slow channels divide 15.625 MHz by an integer 2 to 2^24-1.
// - slow duty step is one slow source period.
// - slow pins are selectable as inputs or modulator outputs.
// - each fast channel has a phase offset over the full period.
// - margining is commanded by operation register or two pins.
// - margin options ignore faults and trim once at power up.
// - open-loop margining drives two open-drain resistor switches.
// - closed loop steers duty until rail reaches margin target.
// - target resolution equals measurement resolution.
// - duty to voltage direction is configurable.
// - tristate idle floats margin pin; disable mode stops margining.
// - tracking idle holds the rail at the commanded setpoint.
// - fixed idle outputs a configured duty.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module pmu_top (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  input  wire pmu_pkg::pmu_meas_t    meas_i,
  input  wire logic                  margin_req_i,
  input  wire logic                  margin_dir_i,
  input  wire logic [1:0]            slow_in_i,
  output pmu_pkg::pmu_pin_t [7:0]    fast_pin_o,
  output pmu_pkg::pmu_pin_t [1:0]    slow_pin_o,
  output pmu_pkg::pmu_pin_t          margin_up_o,
  output pmu_pkg::pmu_pin_t          margin_dn_o,
  output logic                       margin_ignore_faults_o
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // position in period after phase shift; phase at or above period wraps
  function automatic logic [13:0] shifted(input logic [13:0] cnt,
                                          input logic [13:0] ph,
                                          input logic [13:0] per);
    logic [13:0] p;
    p = (ph >= per) ? 14'(ph - per) : ph;
    return (cnt >= p) ? 14'(cnt - p) : 14'(cnt + per - p);
  endfunction

  // clamp a divisor to its legal minimum
  function automatic logic [13:0] fclamp(input logic [13:0] d);
    return (d < pmu_pkg::FDIV_MIN) ? pmu_pkg::FDIV_MIN : d;
  endfunction

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [13:0] per_w   [4];
  logic [17:0] duty_w  [8];
  logic [13:0] ph_w    [8];
  logic [3:0]  fctl    [8];
  logic [23:0] sper_w  [2];
  logic [23:0] sduty_w [2];
  logic [1:0]  sctl;
  logic [6:0]  mcfg;
  logic [7:0]  oper;
  logic [11:0] mlow;
  logic [11:0] mhigh;
  logic [11:0] vcmd;
  logic [13:0] fixdu;
  logic [13:0] mduty;
  logic        m_active;
  logic        trim_pend;
  logic        trim_on;

  logic [7:0]  a;
  assign a = addr_i;

  // software writes; the shadows below keep these from cutting a pulse
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        per_w[i] <= pmu_pkg::RST_FDIV;
      end
      for (int i = 0; i < 8; i++) begin
        duty_w[i] <= 18'h0_0000;
        ph_w[i]   <= 14'h0000;
        fctl[i]   <= 4'h0;
      end
      for (int i = 0; i < 2; i++) begin
        sper_w[i]  <= pmu_pkg::RST_SDIV;
        sduty_w[i] <= 24'h00_0000;
      end
      sctl  <= 2'h0;
      mcfg  <= 7'h00;
      oper  <= 8'h00;
      mlow  <= 12'h000;
      mhigh <= 12'h000;
      vcmd  <= 12'h000;
      fixdu <= 14'h0000;
    end else if (wr_i) begin
      if (a[7:4] == pmu_pkg::OFS_PERIOD[7:4]) per_w[a[3:2]] <= wdata_i[13:0];
      if (a >= pmu_pkg::OFS_FDUTY && a < pmu_pkg::OFS_PHASE)
        duty_w[a[4:2] ^ 3'h4] <= wdata_i[17:0];
      if (a >= pmu_pkg::OFS_PHASE && a < pmu_pkg::OFS_FCTL)
        ph_w[3'(a[5:2] - pmu_pkg::OFS_PHASE[5:2])] <= wdata_i[13:0];
      if (a >= pmu_pkg::OFS_FCTL && a < pmu_pkg::OFS_SPER)
        fctl[3'(a[5:2] - pmu_pkg::OFS_FCTL[5:2])] <= wdata_i[3:0];
      if (a == pmu_pkg::OFS_SPER || a == 8'h74) sper_w[a[2]] <= wdata_i[23:0];
      if (a == pmu_pkg::OFS_SDUTY || a == 8'h7C) sduty_w[a[2]] <= wdata_i[23:0];
      if (a == pmu_pkg::OFS_SCTL)  sctl  <= wdata_i[1:0];
      if (a == pmu_pkg::OFS_MCFG)  mcfg  <= wdata_i[6:0];
      if (a == pmu_pkg::OFS_OPER)  oper  <= wdata_i[7:0];
      if (a == pmu_pkg::OFS_MLOW)  mlow  <= wdata_i[11:0];
      if (a == pmu_pkg::OFS_MHIGH) mhigh <= wdata_i[11:0];
      if (a == pmu_pkg::OFS_VCMD)  vcmd  <= wdata_i[11:0];
      if (a == pmu_pkg::OFS_FIXDU) fixdu <= wdata_i[13:0];
    end
  end

  // read data stands one cycle after the strobe and holds until the next read
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= 32'h0000_0000;
      if (a[7:4] == 4'h0) rdata_o <= {18'h0, per_w[a[3:2]]};
      if (a >= pmu_pkg::OFS_FDUTY && a < pmu_pkg::OFS_PHASE)
        rdata_o <= {14'h0, duty_w[a[4:2] ^ 3'h4]};
      if (a >= pmu_pkg::OFS_PHASE && a < pmu_pkg::OFS_FCTL)
        rdata_o <= {18'h0, ph_w[3'(a[5:2] - pmu_pkg::OFS_PHASE[5:2])]};
      if (a >= pmu_pkg::OFS_FCTL && a < pmu_pkg::OFS_SPER)
        rdata_o <= {28'h0, fctl[3'(a[5:2] - pmu_pkg::OFS_FCTL[5:2])]};
      if (a == pmu_pkg::OFS_SPER || a == 8'h74) rdata_o <= {8'h0, sper_w[a[2]]};
      if (a == pmu_pkg::OFS_SDUTY || a == 8'h7C) rdata_o <= {8'h0, sduty_w[a[2]]};
      if (a == pmu_pkg::OFS_SCTL)  rdata_o <= {30'h0, sctl};
      if (a == pmu_pkg::OFS_MCFG)  rdata_o <= {25'h0, mcfg};
      if (a == pmu_pkg::OFS_OPER)  rdata_o <= {24'h0, oper};
      if (a == pmu_pkg::OFS_MLOW)  rdata_o <= {20'h0, mlow};
      if (a == pmu_pkg::OFS_MHIGH) rdata_o <= {20'h0, mhigh};
      if (a == pmu_pkg::OFS_VCMD)  rdata_o <= {20'h0, vcmd};
      if (a == pmu_pkg::OFS_FIXDU) rdata_o <= {18'h0, fixdu};
      // status: margin duty, active, trim pending, slow pin levels
      if (a == pmu_pkg::OFS_STAT)
        rdata_o <= {14'h0, slow_in_i, trim_pend, m_active, mduty};
    end
  end

  // ----------------------------------------------------------------------
  // fast modulators
  // ----------------------------------------------------------------------
  logic [13:0] per_a  [4];
  logic [13:0] cnt    [4];
  logic [17:0] duty_a [8];
  logic [13:0] ph_a   [8];
  logic [13:0] mdu_a;
  logic [4:0]  facc   [8];
  logic        wrap   [4];

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      wrap[p] = (cnt[p] >= 14'(per_a[p] - 14'h0001));
    end
  end

  // one counter per pair counts 0 .. divisor-1
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < 4; p++) begin
        cnt[p]   <= 14'h0000;
        per_a[p] <= pmu_pkg::RST_FDIV;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (wrap[p]) begin
          cnt[p] <= 14'h0000;
          // divisor taken only at the boundary
          per_a[p] <= fclamp(per_w[p]);
        end else begin
          cnt[p] <= 14'(cnt[p] + 14'h0001);
        end
      end
    end
  end

  // per-channel shadows and fraction dither, reloaded at the pair boundary
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++) begin
        duty_a[i] <= 18'h0_0000;
        ph_a[i]   <= 14'h0000;
        facc[i]   <= 5'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wrap[i/2]) begin
          // duty and phase change only between periods
          duty_a[i] <= duty_w[i];
          ph_a[i]   <= ph_w[i];
          // fraction accumulates, carry lengthens one period's high time by a cycle
          facc[i]   <= {1'b0, facc[i][3:0]} + {1'b0, duty_w[i][3:0]};
        end
      end
    end
  end

  // fast pin drivers, registered
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++) begin
        fast_pin_o[i] <= '{out: 1'b0, oe: 1'b1};
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        logic [13:0] pos;
        logic [14:0] hi;
        logic        own_pwm;
        pos = shifted(cnt[i/2], ph_a[i], per_a[i/2]);
        hi  = {1'b0, duty_a[i][17:4]} + {14'h0, facc[i][4]};
        // unassigned partner follows an enabled channel
        own_pwm = (fctl[i][1:0] == pmu_pkg::FM_PWM) ||
                  (fctl[i][1:0] == pmu_pkg::FM_UNUSED &&
                   fctl[i^1][1:0] == pmu_pkg::FM_PWM);
        if (own_pwm) begin
          fast_pin_o[i] <= '{out: ({1'b0, pos} < hi), oe: 1'b1};
        end else if (fctl[i][1:0] == pmu_pkg::FM_MARGIN) begin
          // tristate idle floats the pin, disable holds it low
          if (mcfg[1:0] == pmu_pkg::MI_DISABLE || mcfg[pmu_pkg::MCFG_OPEN])
            fast_pin_o[i] <= '{out: 1'b0, oe: 1'b1};
          else if (mcfg[1:0] == pmu_pkg::MI_TRISTATE && !m_active && !trim_on)
            fast_pin_o[i] <= '{out: 1'b0, oe: 1'b0};
          else
            fast_pin_o[i] <= '{out: (pos < mdu_a), oe: 1'b1};
        end else if (fctl[i][1:0] == pmu_pkg::FM_GPO) begin
          // general output, push-pull or open drain
          if (fctl[i][pmu_pkg::FCTL_OD])
            fast_pin_o[i] <= '{out: 1'b0, oe: !fctl[i][pmu_pkg::FCTL_LVL]};
          else
            fast_pin_o[i] <= '{out: fctl[i][pmu_pkg::FCTL_LVL], oe: 1'b1};
        end else begin
          fast_pin_o[i] <= '{out: 1'b0, oe: 1'b1};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // slow modulators on a 15.625 MHz enable
  // ----------------------------------------------------------------------
  logic [5:0]  sacc;
  logic        stick;
  logic [23:0] scnt   [2];
  logic [23:0] sper_a [2];
  logic [23:0] sdu_a  [2];

  // fractional divider gives exact 15.625 MHz ticks on average
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sacc  <= 6'h00;
      stick <= 1'b0;
    end else if (6'(sacc + pmu_pkg::SLOW_INC) >= pmu_pkg::SLOW_MOD) begin
      sacc  <= 6'(sacc + pmu_pkg::SLOW_INC - pmu_pkg::SLOW_MOD);
      stick <= 1'b1;
    end else begin
      sacc  <= 6'(sacc + pmu_pkg::SLOW_INC);
      stick <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int s = 0; s < 2; s++) begin
        scnt[s]   <= 24'h00_0000;
        sper_a[s] <= pmu_pkg::RST_SDIV;
        sdu_a[s]  <= 24'h00_0000;
      end
    end else if (stick) begin
      for (int s = 0; s < 2; s++) begin
        if (scnt[s] >= 24'(sper_a[s] - 24'h00_0001)) begin
          scnt[s] <= 24'h00_0000;
          // slow settings also wait for the boundary
          sper_a[s] <= (sper_w[s] < pmu_pkg::SDIV_MIN) ? pmu_pkg::SDIV_MIN : sper_w[s];
          sdu_a[s]  <= sduty_w[s];
        end else begin
          scnt[s] <= 24'(scnt[s] + 24'h00_0001);
        end
      end
    end
  end

  // one count of duty is one slow source period
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slow_pin_o <= '{default: '{out: 1'b0, oe: 1'b0}};
    end else begin
      for (int s = 0; s < 2; s++) begin
        // control bit picks input (released) or modulator output
        slow_pin_o[s] <= '{out: sctl[s] && (scnt[s] < sdu_a[s]), oe: sctl[s]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // margining
  // ----------------------------------------------------------------------
  logic        m_high;
  logic [11:0] target;
  logic        regulate;
  logic        ctl_per;

  // command from the operation register or the two pins
  always_comb begin
    trim_on = trim_pend && mcfg[pmu_pkg::MCFG_TRIM];
    if (mcfg[pmu_pkg::MCFG_PIN]) begin
      m_active = margin_req_i;
      m_high   = margin_dir_i;
    end else begin
      m_active = oper[pmu_pkg::OPER_LOW] ^ oper[pmu_pkg::OPER_HIGH];
      m_high   = oper[pmu_pkg::OPER_HIGH];
    end
    if (mcfg[1:0] == pmu_pkg::MI_DISABLE) m_active = 1'b0;
    // target is margin low or high, else the setpoint
    target   = m_active ? (m_high ? mhigh : mlow) : vcmd;
    // tracking idle keeps regulating to the setpoint
    regulate = !mcfg[pmu_pkg::MCFG_OPEN] && mcfg[1:0] != pmu_pkg::MI_DISABLE &&
               (m_active || trim_on || mcfg[1:0] == pmu_pkg::MI_TRACK);
  end
  assign ctl_per = per_a[0] > 14'h0000;

  // closed-loop duty, bounded by pair 0's period; each margin pin compares it with its own pair's count
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mduty <= 14'h0000;
    end else if (regulate && meas_i.valid && ctl_per) begin
      // one step per new measurement; direction selectable
      if (meas_i.code < target) begin
        if (!mcfg[pmu_pkg::MCFG_INV] && mduty < per_a[0]) mduty <= 14'(mduty + 14'h0001);
        if (mcfg[pmu_pkg::MCFG_INV] && mduty != 14'h0000) mduty <= 14'(mduty - 14'h0001);
      end else if (meas_i.code > target) begin
        if (mcfg[pmu_pkg::MCFG_INV] && mduty < per_a[0]) mduty <= 14'(mduty + 14'h0001);
        if (!mcfg[pmu_pkg::MCFG_INV] && mduty != 14'h0000) mduty <= 14'(mduty - 14'h0001);
      end
    end else if (!regulate && mcfg[1:0] == pmu_pkg::MI_FIXED) begin
      mduty <= fixdu;
    end
  end

  // trim pends from reset and acts only once enabled, so late setup still works
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trim_pend <= 1'b1;
    end else if (mcfg[pmu_pkg::MCFG_TRIM] && meas_i.valid && meas_i.code == vcmd) begin
      trim_pend <= 1'b0;
    end
  end

  // margin duty shadow, taken at pair 0's boundary
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mdu_a <= 14'h0000;
    end else if (wrap[0]) begin
      // margin duty is glitch free too on pair 0's pins
      mdu_a <= mduty;
    end
  end

  // open-loop switches pull resistors via open-drain outputs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      margin_up_o            <= '{out: 1'b0, oe: 1'b0};
      margin_dn_o            <= '{out: 1'b0, oe: 1'b0};
      margin_ignore_faults_o <= 1'b0;
    end else begin
      margin_up_o <= '{out: 1'b0, oe: mcfg[pmu_pkg::MCFG_OPEN] && m_active && m_high};
      margin_dn_o <= '{out: 1'b0, oe: mcfg[pmu_pkg::MCFG_OPEN] && m_active && !m_high};
      margin_ignore_faults_o <= mcfg[pmu_pkg::MCFG_IGN] && m_active;
    end
  end
endmodule

// File: pmu_pkg.sv
// Purpose: shared constants and types of the modulator and margining unit
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   offsets (the second slow channel's excepted), field positions, reset divisors and rates live here
package pmu_pkg;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_FAST  = 8;
  localparam int NUM_PAIR  = 4;
  localparam int NUM_SLOW  = 2;
  localparam int FDIV_W    = 14;
  localparam int SDIV_W    = 24;
  localparam int FRAC_W    = 4;
  localparam int ADC_W     = 12;
  localparam logic [FDIV_W-1:0] FDIV_MIN = 14'h0002;
  localparam logic [SDIV_W-1:0] SDIV_MIN = 24'h00_0002;

  // ----------------------------------------------------------------------
  // slow source rate: 100 MHz * 5 / 32 = 15.625 MHz exactly
  // ----------------------------------------------------------------------
  localparam int          CLK_KHZ   = 100000;
  localparam int          SLOW_KHZ  = 15625;
  localparam logic [5:0]  SLOW_INC  = 6'(SLOW_KHZ * 32 / CLK_KHZ);
  localparam logic [5:0]  SLOW_MOD  = 6'h20;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PERIOD = 8'h00;
  localparam logic [7:0] OFS_FDUTY  = 8'h10;
  localparam logic [7:0] OFS_PHASE  = 8'h30;
  localparam logic [7:0] OFS_FCTL   = 8'h50;
  localparam logic [7:0] OFS_SPER   = 8'h70;
  localparam logic [7:0] OFS_SDUTY  = 8'h78;
  localparam logic [7:0] OFS_SCTL   = 8'h80;
  localparam logic [7:0] OFS_MCFG   = 8'h84;
  localparam logic [7:0] OFS_OPER   = 8'h88;
  localparam logic [7:0] OFS_MLOW   = 8'h8C;
  localparam logic [7:0] OFS_MHIGH  = 8'h90;
  localparam logic [7:0] OFS_VCMD   = 8'h94;
  localparam logic [7:0] OFS_FIXDU  = 8'h98;
  localparam logic [7:0] OFS_STAT   = 8'h9C;

  // ----------------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------------
  localparam int FCTL_LVL  = 2;
  localparam int FCTL_OD   = 3;
  localparam int MCFG_IDLE = 0;
  localparam int MCFG_INV  = 2;
  localparam int MCFG_PIN  = 3;
  localparam int MCFG_OPEN = 4;
  localparam int MCFG_IGN  = 5;
  localparam int MCFG_TRIM = 6;
  localparam int OPER_LOW  = 4;
  localparam int OPER_HIGH = 5;
  localparam logic [1:0]  RST_MODE  = 2'h0;
  localparam logic [13:0] RST_FDIV  = 14'h0002;
  localparam logic [23:0] RST_SDIV  = 24'h00_0002;

  typedef enum logic [1:0] {FM_UNUSED, FM_GPO, FM_PWM, FM_MARGIN} pmu_fmode_t;
  typedef enum logic [1:0] {MI_DISABLE, MI_TRISTATE, MI_TRACK, MI_FIXED} pmu_idle_t;

  typedef struct packed {
    logic             valid;
    logic [ADC_W-1:0] code;
  } pmu_meas_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pmu_pin_t;
endpackage

// File: pmu_rc_model.sv
// Purpose: rail model behind the margining filter of fast channel 0
// Assumes: one measurement is taken per fire_i pulse
// Notes:   rail code is base_i plus the high time seen over 16 clocks
`timescale 1ns/1ps
module pmu_rc_model (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire pmu_pkg::pmu_pin_t pin_i,
  input  wire logic [11:0]       base_i,
  input  wire logic              fire_i,
  output pmu_pkg::pmu_meas_t     meas_o
);
  logic [15:0] hist;

  // rail follows filtered duty
  // a floating pin adds no charge, so tristate never lifts the rail
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hist   <= 16'h0000;
      meas_o <= '0;
    end else begin
      hist         <= {hist[14:0], pin_i.oe & pin_i.out};
      meas_o.valid <= fire_i;
      meas_o.code  <= base_i + 12'($countones(hist));
    end
  end
endmodule

// File: pmu_top_asserts.sv
// Purpose: port-level checks of the modulator and margining unit
// Assumes: register strobes follow the one-cycle port contract
// Notes:   pin timing inside a period is left to the bench
`timescale 1ns/1ps
module pmu_top_asserts (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  input  wire logic [31:0]            rdata_o,
  input  wire logic [1:0]             slow_in_i,
  input  wire pmu_pkg::pmu_pin_t [7:0] fast_pin_o,
  input  wire pmu_pkg::pmu_pin_t [1:0] slow_pin_o,
  input  wire pmu_pkg::pmu_pin_t      margin_up_o,
  input  wire pmu_pkg::pmu_pin_t      margin_dn_o
);
  logic [1:0] oper_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // shadow of the margin request bits, to judge readback
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oper_q <= 2'h0;
    end else if (wr_i && addr_i == pmu_pkg::OFS_OPER) begin
      oper_q <= wdata_i[5:4];
    end
  end

  a_rst_fast_low: assert property ($fell(sys_rst_i) |-> fast_pin_o == 16'h5555)
    else $error("fast pins not driven low after reset");
  a_rst_slow_in: assert property ($fell(sys_rst_i) |-> !(slow_pin_o[0].oe | slow_pin_o[1].oe))
    else $error("slow pins drive after reset");
  a_od_never_high: assert property (!margin_up_o.out && !margin_dn_o.out)
    else $error("open-drain margin pin drives high");
  a_od_one_side: assert property (!(margin_up_o.oe && margin_dn_o.oe))
    else $error("both margin resistors switched");
  a_fdiv_width: assert property (rd_i && addr_i == pmu_pkg::OFS_PERIOD |=> rdata_o[31:14] == 18'h0)
    else $error("fast divisor wider than 14 bits");
  a_sdiv_width: assert property (rd_i && addr_i == pmu_pkg::OFS_SPER |=> rdata_o[31:24] == 8'h00)
    else $error("slow divisor wider than 24 bits");
  a_slow_in_seen: assert property (rd_i && addr_i == pmu_pkg::OFS_STAT |=> rdata_o[17:16] == $past(slow_in_i))
    else $error("slow input levels misreported");
  a_oper_readback: assert property (rd_i && addr_i == pmu_pkg::OFS_OPER |=> rdata_o[5:4] == $past(oper_q))
    else $error("margin request bits lost");
endmodule

bind pmu_top pmu_top_asserts i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_in_i(slow_in_i),
  .fast_pin_o(fast_pin_o), .slow_pin_o(slow_pin_o), .margin_up_o(margin_up_o),
  .margin_dn_o(margin_dn_o));

// File: pmu_top_bench.sv
// Purpose: self-checking bench of the modulator and margining unit
// Assumes: pmu_rc_model closes the rail loop on fast channel 0
// Notes:   high-time counts over whole dither cycles stand in for edges
`timescale 1ns/1ps
module pmu_top_bench;
  logic                    clk_i, sys_rst_i, wr_i, rd_i, fire;
  logic                    margin_req_i, margin_dir_i, ign;
  logic [7:0]              addr_i;
  logic [31:0]             wdata_i, rdata_o, d;
  logic [1:0]              slow_in_i;
  logic [11:0]             base;
  pmu_pkg::pmu_meas_t      meas_i;
  pmu_pkg::pmu_pin_t [7:0] fast_pin_o;
  pmu_pkg::pmu_pin_t [1:0] slow_pin_o;
  pmu_pkg::pmu_pin_t       margin_up_o, margin_dn_o;
  int                      num_errors, compares, k;

  pmu_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas_i),
    .margin_req_i(margin_req_i), .margin_dir_i(margin_dir_i), .slow_in_i(slow_in_i),
    .fast_pin_o(fast_pin_o), .slow_pin_o(slow_pin_o), .margin_up_o(margin_up_o),
    .margin_dn_o(margin_dn_o), .margin_ignore_faults_o(ign));
  pmu_rc_model i_rail (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pin_i(fast_pin_o[0]),
    .base_i(base), .fire_i(fire), .meas_o(meas_i));

  // free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  // read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // high cycles of a fast pin (0..7) or a slow pin (8..9)
  task automatic cnt(input int ch, input int n);
    k = 0;
    repeat (n) begin
      @(negedge clk_i);
      k += int'((ch < 8) ? fast_pin_o[ch].out : slow_pin_o[ch-8].out);
    end
  endtask
  // one rail measurement, then let the loop settle
  task automatic pulse;
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic conclude;
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // reset drive and register reset values
  task automatic t_reset;
    @(negedge clk_i);
    chk(32'(fast_pin_o), 32'h5555);
    rd(8'h00);
    chk(d, 32'h2);
    rd(8'h70);
    chk(d, 32'h2);
    rd(8'hA0);
    chk(d, 32'h0);
  endtask
  // divisor range, dither, partner follow, phase
  task automatic t_pwm;
    wr(8'h04, 32'h3FFF);
    rd(8'h04);
    chk(d, 32'h3FFF);
    wr(8'h2C, 32'h3_FFFF);
    rd(8'h2C);
    chk(d, 32'h3_FFFF);
    wr(8'h00, 32'h4);
    wr(8'h10, 32'h28);
    wr(8'h14, 32'h18);
    wr(8'h50, 32'h2);
    repeat (40) @(posedge clk_i);
    cnt(0, 64);
    chk(32'(k), 32'd40);
    cnt(1, 64);
    chk(32'(k), 32'd24);
    wr(8'h10, 32'h20);
    wr(8'h14, 32'h20);
    wr(8'h34, 32'h2);
    repeat (40) @(posedge clk_i);
    k = 0;
    repeat (16) begin
      @(negedge clk_i);
      k += int'(fast_pin_o[0].out !== fast_pin_o[1].out);
    end
    chk(32'(k), 32'd16);
  endtask
  // general outputs beside a modulating pair
  task automatic t_gpo;
    wr(8'h58, 32'h5);
    wr(8'h5C, 32'h9);
    repeat (4) @(posedge clk_i);
    chk(32'(fast_pin_o[2]), 32'h3);
    chk(32'(fast_pin_o[3]), 32'h1);
  endtask
  // tracking loop, direction, margin by register and by pins
  task automatic t_loop;
    wr(8'h00, 32'h10);
    wr(8'h50, 32'h3);
    wr(8'h94, 32'd100);
    wr(8'h84, 32'h2);
    rd(8'h9C);
    k = int'(d[13:0]);
    pulse;
    rd(8'h9C);
    chk(32'(d[13:0]), 32'(k + 1));
    wr(8'h84, 32'h6);
    pulse;
    rd(8'h9C);
    chk(32'(d[13:0]), 32'(k));
    wr(8'h8C, 32'hFFFF);
    rd(8'h8C);
    chk(d, 32'hFFF);
    wr(8'h90, 32'hFFF);
    wr(8'h84, 32'h22);
    wr(8'h88, 32'h20);
    pulse;
    rd(8'h9C);
    chk(32'(d[14:0]), 32'h4000 | 32'(k + 1));
    chk(32'(ign), 32'h1);
    wr(8'h88, 32'h0);
    wr(8'h8C, 32'h0);
    wr(8'h84, 32'hA);
    margin_req_i <= 1'b1;
    base         <= 12'hF00;
    pulse;
    rd(8'h9C);
    chk(32'(d[14:0]), 32'h4000 | 32'(k));
    @(posedge clk_i);
    margin_req_i <= 1'b0;
    base         <= 12'h000;
  endtask
  // idle modes and open-loop switches
  task automatic t_idle;
    wr(8'h84, 32'h1);
    repeat (40) @(posedge clk_i);
    chk(32'(fast_pin_o[0].oe), 32'h0);
    wr(8'h84, 32'h0);
    repeat (40) @(posedge clk_i);
    chk(32'(fast_pin_o[0]), 32'h1);
    wr(8'h98, 32'h7);
    wr(8'h84, 32'h3);
    repeat (40) @(posedge clk_i);
    rd(8'h9C);
    chk(32'(d[13:0]), 32'h7);
    wr(8'h84, 32'h11);
    wr(8'h88, 32'h20);
    repeat (4) @(posedge clk_i);
    chk(32'({margin_up_o.oe, margin_dn_o.oe}), 32'h2);
    wr(8'h88, 32'h10);
    rd(8'h88);
    chk(32'(d[5:4]), 32'h1);
    chk(32'({margin_up_o.oe, margin_dn_o.oe}), 32'h1);
    // trim keeps the tristate pin driven until the rail meets setpoint (7 + 93)
    wr(8'h88, 32'h0);
    base <= 12'd93;
    wr(8'h84, 32'h41);
    repeat (40) @(posedge clk_i);
    chk(32'(fast_pin_o[0].oe), 32'h1);
    pulse;
    repeat (40) @(posedge clk_i);
    chk(32'(fast_pin_o[0].oe), 32'h0);
    base <= 12'h000;
  endtask
  // slow modulator duty and input pins
  task automatic t_slow;
    @(posedge clk_i);
    slow_in_i <= 2'b10;
    wr(8'h70, 32'h4);
    wr(8'h78, 32'h2);
    wr(8'h80, 32'h1);
    repeat (300) @(posedge clk_i);
    cnt(8, 256);
    chk(32'(k >= 120 && k <= 136), 32'h1);
    chk(32'(slow_pin_o[1].oe), 32'h0);
    rd(8'h9C);
    chk(32'(d[17:16]), 32'h2);
  endtask

  // a hang counts as a failure
  initial begin
    #200000;
    num_errors++;
    conclude;
  end

  initial begin
    {clk_i, wr_i, rd_i, fire, margin_req_i, margin_dir_i} = '0;
    {addr_i, wdata_i, slow_in_i, base, num_errors, compares} = '0;
    sys_rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_pwm;
    t_gpo;
    t_loop;
    t_idle;
    t_slow;
    conclude;
  end
endmodule
